// [core/tive_defs.svh]
// Register offsets, field positions, reset values and vector codes of the timer vector encoder
`ifndef TIVE_DEFS_SVH
`define TIVE_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TIVE_OFS_VECTOR    12'h000
`define TIVE_OFS_SRC_FLAGS 12'h004
`define TIVE_OFS_HIRES     12'h008
`define TIVE_OFS_IRQ_STAT  12'h00c
`define TIVE_OFS_IRQ_MASK  12'h010

// ****************************************
// Reset values
// ****************************************
`define TIVE_RST_VECTOR   16'h0000
`define TIVE_RST_HIRES    16'h0000
`define TIVE_RST_IRQ_MASK 2'h0

// ****************************************
// High-resolution register fields
// ****************************************
`define TIVE_HIRES_FLAG_LSB 0
`define TIVE_HIRES_EN_LSB   8
`define TIVE_HIRES_REGEN    12

// ****************************************
// Vector codes
// ****************************************
`define TIVE_VEC_NONE      5'h00
`define TIVE_VEC_CH1       5'h02
`define TIVE_VEC_OVERFLOW  5'h10
`define TIVE_VEC_FAIL_LOW  5'h12
`define TIVE_VEC_FAIL_HIGH 5'h14
`define TIVE_VEC_LOCK      5'h16
`define TIVE_VEC_UNLOCK    5'h18

// ****************************************
// Interrupt status bits
// ****************************************
`define TIVE_IRQ_PENDING 0
`define TIVE_IRQ_LOCK    1

`endif

// [core/tive_pkg.sv]
// Types shared by the timer vector encoder
package tive_pkg;

  typedef struct packed {
    logic [5:0] channel;
    logic       overflow;
    logic       fail_low;
    logic       fail_high;
    logic       lock;
    logic       unlock;
  } tive_events_s;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        active;
  } tive_ahb_req_s;

  typedef enum logic {TIVE_IDLE, TIVE_DATA} tive_phase_e;

endpackage : tive_pkg

// [core/tive_core.sv]
// Prioritised timer interrupt vector encoder with AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tive_defs.svh"

module tive_core (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // AHB-Lite slave
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic      [31:0]         hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  // Flag-setting pulses from the timer, same clock
  input  wire tive_pkg::tive_events_s set_i,
  input  wire logic                calib_done_i,
  // Pending flags and interrupt
  output tive_pkg::tive_events_s   flags_o,
  output logic                     irq_o
);
  import tive_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  tive_ahb_req_s req_r, req_nxt;
  tive_phase_e   phase_r, phase_nxt;

  always_comb begin
    req_nxt   = req_r;
    phase_nxt = TIVE_IDLE;
    if (hready_i) begin
      req_nxt.active = hsel_i && htrans_i[1];
      req_nxt.addr   = haddr_i;
      req_nxt.write  = hwrite_i;
      if (hsel_i && htrans_i[1]) begin
        phase_nxt = TIVE_DATA;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      req_r   <= '0;
      phase_r <= TIVE_IDLE;
    end else begin
      req_r   <= req_nxt;
      phase_r <= phase_nxt;
    end
  end

  wire logic wr_data = (phase_r == TIVE_DATA) && req_r.write;
  wire logic rd_addr = hready_i && hsel_i && htrans_i[1] && !hwrite_i;
  wire logic [11:0] rd_ofs = haddr_i[11:0];
  wire logic [11:0] wr_ofs = req_r.addr[11:0];

  // ****************************************
  // Priority encoder
  // ****************************************
  tive_events_s flags_r, flags_nxt;
  logic [3:0]   hires_en_r, hires_en_nxt;
  logic         regen_r, regen_nxt;
  logic [4:0]   code;
  logic [10:0]  report;
  logic [10:0]  eligible;

  always_comb begin
    // Order matches priority: channels first, unlock last
    eligible = {flags_r.channel[0], flags_r.channel[1], flags_r.channel[2],
                flags_r.channel[3], flags_r.channel[4], flags_r.channel[5],
                flags_r.overflow,
                flags_r.fail_low  && hires_en_r[0],
                flags_r.fail_high && hires_en_r[1],
                flags_r.lock      && hires_en_r[2],
                flags_r.unlock    && hires_en_r[3]};
    code   = `TIVE_VEC_NONE;
    report = '0;
    for (int i = 0; i < 11; i++) begin
      // Highest index is highest priority; first hit wins, codes skip reserved slots
      if (eligible[10 - i] && code == `TIVE_VEC_NONE) begin
        report[10 - i] = 1'b1;
        if (i < 6) begin
          code = `TIVE_VEC_CH1 + 5'(2 * i);
        end else begin
          code = `TIVE_VEC_OVERFLOW + 5'(2 * (i - 6));
        end
      end
    end
  end

  // ****************************************
  // Flags and high-resolution control
  // ****************************************
  logic [15:0] hires_wdata;
  logic [10:0] rd_clear;

  always_comb begin
    hires_wdata  = hwdata_i[15:0];
    rd_clear     = (rd_addr && rd_ofs == `TIVE_OFS_VECTOR) ? report : 11'h000;
    hires_en_nxt = hires_en_r;
    regen_nxt    = regen_r;
    flags_nxt    = flags_r;
    // Clear first so a set in the same cycle wins
    for (int c = 0; c < 6; c++) begin
      if (rd_clear[10 - c]) flags_nxt.channel[c] = 1'b0;
    end
    if (rd_clear[4]) flags_nxt.overflow  = 1'b0;
    if (rd_clear[3]) flags_nxt.fail_low  = 1'b0;
    if (rd_clear[2]) flags_nxt.fail_high = 1'b0;
    if (rd_clear[1]) flags_nxt.lock      = 1'b0;
    if (rd_clear[0]) flags_nxt.unlock    = 1'b0;
    if (wr_data && wr_ofs == `TIVE_OFS_HIRES) begin
      hires_en_nxt = hires_wdata[`TIVE_HIRES_EN_LSB +: 4];
      regen_nxt    = hires_wdata[`TIVE_HIRES_REGEN];
      // Write one clears a monitor flag
      if (hires_wdata[`TIVE_HIRES_FLAG_LSB + 0]) flags_nxt.fail_low  = 1'b0;
      if (hires_wdata[`TIVE_HIRES_FLAG_LSB + 1]) flags_nxt.fail_high = 1'b0;
      if (hires_wdata[`TIVE_HIRES_FLAG_LSB + 2]) flags_nxt.lock      = 1'b0;
      if (hires_wdata[`TIVE_HIRES_FLAG_LSB + 3]) flags_nxt.unlock    = 1'b0;
    end
    if (wr_data && wr_ofs == `TIVE_OFS_SRC_FLAGS) begin
      flags_nxt.channel  = flags_nxt.channel  & ~hwdata_i[5:0];
      flags_nxt.overflow = flags_nxt.overflow & ~hwdata_i[6];
    end
    flags_nxt.channel   = flags_nxt.channel | set_i.channel;
    flags_nxt.overflow  = flags_nxt.overflow  | set_i.overflow;
    flags_nxt.fail_low  = flags_nxt.fail_low  | set_i.fail_low;
    flags_nxt.fail_high = flags_nxt.fail_high | set_i.fail_high;
    // Lock and unlock only count while regulation runs
    flags_nxt.lock   = flags_nxt.lock   | (set_i.lock && calib_done_i && regen_r);
    flags_nxt.unlock = flags_nxt.unlock | (set_i.unlock && regen_r);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags_r    <= '0;
      hires_en_r <= 4'(`TIVE_RST_HIRES >> `TIVE_HIRES_EN_LSB);
      regen_r    <= 1'b0;
    end else begin
      flags_r    <= flags_nxt;
      hires_en_r <= hires_en_nxt;
      regen_r    <= regen_nxt;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  logic [1:0] istat_r, istat_nxt;
  logic [1:0] imask_r, imask_nxt;
  logic       irq_nxt;
  logic       lock_seen;

  always_comb begin
    lock_seen = flags_nxt.lock && !flags_r.lock;
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    if (wr_data && wr_ofs == `TIVE_OFS_IRQ_STAT) begin
      istat_nxt = istat_r & ~hwdata_i[1:0];
    end
    if (wr_data && wr_ofs == `TIVE_OFS_IRQ_MASK) begin
      imask_nxt = hwdata_i[1:0];
    end
    // Set beats clear
    if (code != `TIVE_VEC_NONE) istat_nxt[`TIVE_IRQ_PENDING] = 1'b1;
    if (lock_seen) istat_nxt[`TIVE_IRQ_LOCK] = 1'b1;
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      istat_r <= '0;
      imask_r <= `TIVE_RST_IRQ_MASK;
      irq_o   <= 1'b0;
      flags_o <= '0;
    end else begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_o   <= irq_nxt;
      flags_o <= flags_nxt;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [15:0] vector_val;
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    // Vector is a read-only snapshot; no write path reaches it
    vector_val = {11'h000, code[4:1], 1'b0};
    rdata_nxt  = 32'h0000_0000;
    if (rd_addr) begin
      unique case (rd_ofs)
        `TIVE_OFS_VECTOR:    rdata_nxt = {16'h0000, vector_val};
        `TIVE_OFS_SRC_FLAGS: rdata_nxt = {25'h0, flags_r.overflow, flags_r.channel};
        `TIVE_OFS_HIRES:     rdata_nxt = {19'h0, regen_r, hires_en_r, 4'h0,
                                          flags_r.unlock, flags_r.lock, flags_r.fail_high, flags_r.fail_low};
        `TIVE_OFS_IRQ_STAT:  rdata_nxt = {30'h0, istat_r};
        `TIVE_OFS_IRQ_MASK:  rdata_nxt = {30'h0, imask_r};
        default:             rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_r  <= {16'h0000, `TIVE_RST_VECTOR};
    end else begin
      rdata_r  <= rdata_nxt;
    end
  end

  always_comb begin
    hrdata_o    = rdata_r;
    hreadyout_o = 1'b1;
    hresp_o     = 1'b0;
  end

endmodule : tive_core
`default_nettype wire

// [bench/tive_chk.sv]
// Port checker for the timer vector encoder
`timescale 1ns/1ps
`default_nettype none
module tive_chk (
  // Clock, reset and bus
  input wire logic                   ref_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   hsel_i,
  input wire logic [31:0]            haddr_i,
  input wire logic [1:0]             htrans_i,
  input wire logic                   hwrite_i,
  input wire logic                   hready_i,
  input wire logic [31:0]            hrdata_o,
  // Events and flags
  input wire tive_pkg::tive_events_s set_i,
  input wire logic                   calib_done_i,
  input wire tive_pkg::tive_events_s flags_o
);
  import tive_pkg::*;
  logic       acc_vec;
  logic       rd_vec;
  logic [4:0] code;
  assign acc_vec = hsel_i && htrans_i[1] && hready_i && haddr_i == 32'h0;
  assign rd_vec  = acc_vec && !hwrite_i;
  // Lowest channel number wins
  always_comb begin
    code = 5'h00;
    for (int i = 5; i >= 0; i--) begin
      if (flags_o.channel[i]) begin
        code = 5'(2 * i + 2);
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_idle_zero: assert property (rd_vec && flags_o == '0 |=> hrdata_o == 32'h0)
    else $error("idle code");
  a_chan_code: assert property (rd_vec && |flags_o.channel |=> hrdata_o == {27'h0, $past(code)})
    else $error("channel code");
  a_ovf_code: assert property (rd_vec && flags_o.channel == '0 && flags_o.overflow |=> hrdata_o == 32'h10)
    else $error("overflow code");
  a_code_shape: assert property (rd_vec |=> hrdata_o[31:5] == '0 && !hrdata_o[0] &&
    !(hrdata_o[4:0] inside {5'h0e, 5'h1a, 5'h1c, 5'h1e})) else $error("bad code shape");
  a_read_clear: assert property (rd_vec && |flags_o.channel && set_i == '0 |=>
    flags_o.channel == $past(flags_o.channel & (flags_o.channel - 6'h1))) else $error("flag not cleared");
  a_lock_cause: assert property ($rose(flags_o.lock) |-> $past(set_i.lock && calib_done_i))
    else $error("lock without cause");
  a_lock_holds: assert property (!hsel_i ##1 flags_o.lock && !hsel_i |=> flags_o.lock)
    else $error("lock dropped");
  a_vec_ro: assert property (acc_vec && hwrite_i && set_i == '0 ##1 !hsel_i && set_i == '0 |=> $stable(flags_o))
    else $error("vector write acted");
  c_all_chan: cover property (rd_vec && flags_o.channel == 6'h3f);
  c_lock_set: cover property ($rose(flags_o.lock));
  c_ovf_read: cover property (rd_vec && flags_o.overflow && flags_o.channel == '0);
endmodule : tive_chk
bind tive_core tive_chk u_chk (.ref_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .set_i, .calib_done_i, .flags_o);
`default_nettype wire

// [bench/tive_host.sv]
// Bus master model standing in for processor software
`timescale 1ns/1ps
`default_nettype none
module tive_host (
  // Clock and answer
  input  wire logic   ref_clk_i,
  input  wire logic   hready_i,
  // Request
  output logic        hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0]  htrans_o,
  output logic        hwrite_o,
  output logic [2:0]  hsize_o,
  output logic [31:0] hwdata_o
);
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
  end
  // Bounded so a dead slave cannot hang the run
  task automatic wait_rdy(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk_i);
      ok = hready_i;
    end
  endtask : wait_rdy
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic ok);
    logic ok_a;
    hsel_o   <= 1'b1;
    haddr_o  <= a;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    wait_rdy(ok_a);
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    // Released lines must not keep the last value
    haddr_o  <= ~a;
    hwdata_o <= d;
    wait_rdy(ok);
    ok = ok && ok_a;
    hwdata_o <= ~d;
  endtask : xfer
endmodule : tive_host
`default_nettype wire

// [bench/tb.sv]
// Self-checking testbench for the timer vector encoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tive_pkg::*;
  logic         ref_clk, rst_n, calib, irq, hsel, hwrite, hrdy;
  logic         dph = 1'b0;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [31:0]  expq[$];
  logic [5:0]   m;
  tive_events_s setv, flags;
  int           mismatches = 0;
  int           cmp_count = 0;
  tive_core dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(), .set_i(setv), .calib_done_i(calib), .flags_o(flags), .irq_o(irq));
  tive_host host (.ref_clk_i(ref_clk), .hready_i(hrdy), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // Reads note their expected value, the monitor below checks it
  task automatic xf(input logic [31:0] a, input logic w, input logic [31:0] d);
    logic ok;
    if (!w) begin
      expq.push_back(d);
    end
    host.xfer(a, w, d, ok);
    if (!ok) begin
      mismatches++;
      end_of_test();
    end
  endtask : xf
  task automatic pulse(input logic [10:0] v);
    setv <= tive_events_s'(v);
    @(posedge ref_clk);
    setv <= '0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse
  task automatic irq_is(input logic v);
    for (int n = 0; n < 8 && irq !== v; n++) begin
      @(posedge ref_clk);
    end
    cmp({31'h0, irq}, {31'h0, v});
  endtask : irq_is
  always @(posedge ref_clk) begin
    if (dph && hrdy) begin
      cmp(hrdata, expq.pop_front());
    end
    if (hrdy) begin
      dph <= hsel && htrans[1] && !hwrite;
    end
  end
  initial begin
    rst_n = 1'b0;
    setv  = '0;
    calib = 1'b0;
    void'($urandom(36));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    xf(32'h0, 1'b0, 32'h0);
    xf(32'hfc, 1'b0, 32'h0);
    pulse(11'h7f0);
    xf(32'h0, 1'b1, 32'hffff);
    for (int c = 2; c <= 14; c += 2) begin
      xf(32'h0, 1'b0, (c == 14) ? 32'h10 : 32'(c));
    end
    xf(32'h0, 1'b0, 32'h0);
    $display("Test done: channels");
    xf(32'h8, 1'b1, 32'h1f00);
    pulse(11'h002);
    xf(32'h0, 1'b0, 32'h0);
    calib <= 1'b1;
    pulse(11'h00f);
    for (int c = 18; c <= 24; c += 2) begin
      xf(32'h0, 1'b0, 32'(c));
    end
    xf(32'h8, 1'b1, 32'h1000);
    pulse(11'h008);
    xf(32'h0, 1'b0, 32'h0);
    xf(32'h8, 1'b1, 32'h1100);
    xf(32'h0, 1'b0, 32'h12);
    $display("Test done: high resolution");
    for (int k = 0; k < 6; k++) begin
      m = 6'($urandom());
      pulse({m, 5'h10});
      for (int i = 0; i < 6; i++) begin
        if (m[i]) begin
          xf(32'h0, 1'b0, 32'(2 * i + 2));
        end
      end
      xf(32'h0, 1'b0, 32'h10);
    end
    xf(32'h10, 1'b1, 32'h1);
    xf(32'hc, 1'b1, 32'h3);
    pulse(11'h020);
    irq_is(1'b1);
    xf(32'h0, 1'b0, 32'h2);
    xf(32'hc, 1'b1, 32'h3);
    irq_is(1'b0);
    $display("Test done: random and interrupts");
    repeat (2) @(posedge ref_clk);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
